// ### src/led_status_ctrl.sv
/*
 * Front-panel status indicator controller for a fieldbus network adapter.
 * Software writes condition and control words over AXI4-Lite; the block
 * turns them into steady, flashing, two-colour and off LED drives.
 * Assumes one 100 MHz clock, synchronous inputs and an active-high LED pin.
 */
// The register offsets and the AXI4-Lite register port were decided locally.
// Summary of operation
// - Supply LED steady green when powered
// - System fault red on listed errors
// - System fault flashes red in force
// - Bus fault red without fieldbus connection
// - Bus fault flashes on config/control/parameter errors
// - Maintenance yellow on system or field bus
// - Module status red: multi-mismatch or no bus
// - Module status flashes red: one mismatch/diagnostics
// - Module status green when ready
// - Module status flashes green when unconfigured
// - Start-up self-test alternates red and green
// - Network status red on IP conflict
// - Network status flashes red on owner timeout
// - Red/green scheme: green with connection
// - Red/green scheme: flashes green without connection
// - Yellow scheme: off with connection
// - Yellow scheme: yellow on conflict/no IP
// - Yellow scheme: slow flash, IP no connection
// - Yellow scheme: fast flash on timeout
// - Port LED steady while link up
// - Port LED flashes on activity, same colour
// - Port colour green fast, yellow slow rate
`default_nettype none
module led_status_ctrl
    import led_status_pkg::*;
#(
    parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
    parameter int unsigned MID_HALF  = MID_HALF_CYC,
    parameter int unsigned FAST_HALF = FAST_HALF_CYC
) (
    // Clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_srst,
    input  wire logic        i_ce,
    // Supply and port status
    input  wire logic        i_supply_ok,
    input  wire logic [1:0]  i_port_link,
    input  wire logic [1:0]  i_port_act,
    input  wire logic [1:0]  i_port_fast,
    // AXI4-Lite slave
    input  wire logic [7:0]  i_awaddr,
    input  wire logic        i_awvalid,
    output logic             o_awready,
    input  wire logic [31:0] i_wdata,
    input  wire logic [3:0]  i_wstrb,
    input  wire logic        i_wvalid,
    output logic             o_wready,
    output logic [1:0]       o_bresp,
    output logic             o_bvalid,
    input  wire logic        i_bready,
    input  wire logic [7:0]  i_araddr,
    input  wire logic        i_arvalid,
    output logic             o_arready,
    output logic [31:0]      o_rdata,
    output logic [1:0]       o_rresp,
    output logic             o_rvalid,
    input  wire logic        i_rready,
    // Indicator drives
    output logic             o_supply_indicator,
    output logic             o_system_fault_indicator,
    output logic             o_bus_fault_indicator,
    output logic             o_maintenance_indicator,
    output rg_led_t          o_module_status_indicator,
    output logic [2:0]       o_network_status_indicator,
    output port_led_t        o_port_one_link_activity_indicator,
    output port_led_t        o_port_two_link_activity_indicator
);
    logic [COND_W-1:0] cond_q;      // Software-written conditions
    logic [1:0]        ctrl_q;      // Scheme select and self-test request
    logic [31:0]       slow_cnt_q;  // 1 Hz half-period counter
    logic [31:0]       mid_cnt_q;   // Common flash counter
    logic [31:0]       fast_cnt_q;  // 4 Hz half-period counter
    logic              slow_q;
    logic              mid_q;
    logic              fast_q;
    logic              mid_tick;
    test_state_t       test_q;      // Self-test sequencer
    logic [2:0]        step_q;      // Self-test half-period count
    logic              testing;
    logic [MISMATCH_W-1:0] mism;
    logic              aw_held_q, w_held_q;
    logic [7:0]        awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic [31:0]       led_word;

    assign mism    = cond_q[C_MISMATCH_LSB +: MISMATCH_W];
    assign testing = (test_q != ST_RUN);

    // Flash timers; all flashing indicators share these phases
    assign mid_tick = (mid_cnt_q == MID_HALF - 1);
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            slow_cnt_q <= '0;
            mid_cnt_q  <= '0;
            fast_cnt_q <= '0;
            slow_q     <= 1'b0;
            mid_q      <= 1'b0;
            fast_q     <= 1'b0;
        end else if (i_ce) begin
            // Common timer near 2 Hz
            if (mid_tick) begin
                mid_cnt_q <= '0;
                mid_q     <= ~mid_q;
            end else begin
                mid_cnt_q <= mid_cnt_q + 32'h0000_0001;
            end
            // 1 Hz slow flash
            if (slow_cnt_q == SLOW_HALF - 1) begin
                slow_cnt_q <= '0;
                slow_q     <= ~slow_q;
            end else begin
                slow_cnt_q <= slow_cnt_q + 32'h0000_0001;
            end
            // 4 Hz fast flash
            if (fast_cnt_q == FAST_HALF - 1) begin
                fast_cnt_q <= '0;
                fast_q     <= ~fast_q;
            end else begin
                fast_cnt_q <= fast_cnt_q + 32'h0000_0001;
            end
        end
    end

    // Self-test after reset or on request: red, green, red, green, then run
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            test_q <= ST_RED;
            step_q <= '0;
        end else if (i_ce) begin
            unique case (test_q)
                ST_RED, ST_GREEN: begin
                    if (mid_tick) begin
                        // Alternate colours each half period
                        if (step_q == 3'(SELFTEST_STEPS - 1)) begin
                            test_q <= ST_RUN;
                        end else begin
                            test_q <= (test_q == ST_RED) ? ST_GREEN : ST_RED;
                            step_q <= step_q + 3'h1;
                        end
                    end
                end
                ST_RUN: begin
                    // Software can rerun the lamp test
                    if (ctrl_q[K_SELFTEST]) begin
                        test_q <= ST_RED;
                        step_q <= '0;
                    end
                end
                default: begin
                    test_q <= ST_RUN;
                end
            endcase
        end
    end

    // Indicator decode, registered so the pins never glitch
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_supply_indicator                 <= 1'b0;
            o_system_fault_indicator           <= 1'b0;
            o_bus_fault_indicator              <= 1'b0;
            o_maintenance_indicator            <= 1'b0;
            o_module_status_indicator          <= '0;
            o_network_status_indicator         <= '0;
            o_port_one_link_activity_indicator <= '0;
            o_port_two_link_activity_indicator <= '0;
        end else if (i_ce) begin
            o_supply_indicator <= i_supply_ok;
            // Steady errors win over force flashing
            if (cond_q[C_CFG_ERR] | cond_q[C_ADP_ERR] | cond_q[C_MOD_ERR] | cond_q[C_NEW_DIAG]) begin
                o_system_fault_indicator <= 1'b1;
            end else begin
                o_system_fault_indicator <= cond_q[C_FORCE] & mid_q;
            end
            // Missing fieldbus wins over flashing causes
            if (cond_q[C_NO_FBUS]) begin
                o_bus_fault_indicator <= 1'b1;
            end else begin
                o_bus_fault_indicator <= (cond_q[C_CFG_ERR] | cond_q[C_NO_CTRL] | cond_q[C_PARAM_ERR]) & mid_q;
            end
            o_maintenance_indicator <= cond_q[C_SBUS_ERR] | cond_q[C_FBUS_ERR];
            // Module status, in priority order
            if (testing) begin
                o_module_status_indicator <= '{red: test_q == ST_RED, green: test_q == ST_GREEN};
            end else if (mism > 7'h01 || cond_q[C_NO_FBUS]) begin
                o_module_status_indicator <= '{red: 1'b1, green: 1'b0};
            end else if (mism == 7'h01 || cond_q[C_MOD_DIAG]) begin
                o_module_status_indicator <= '{red: mid_q, green: 1'b0};
            end else if (cond_q[C_UNCONF]) begin
                o_module_status_indicator <= '{red: 1'b0, green: mid_q};
            end else if (cond_q[C_READY]) begin
                o_module_status_indicator <= '{red: 1'b0, green: 1'b1};
            end else begin
                o_module_status_indicator <= '0;
            end
            // Network status {yellow, green, red}
            if (testing) begin
                o_network_status_indicator <= {1'b0, test_q == ST_GREEN, test_q == ST_RED};
            end else if (ctrl_q[K_YELLOW]) begin
                if (cond_q[C_IP_CONFLICT] || !cond_q[C_IP_VALID]) begin
                    o_network_status_indicator <= 3'b100;
                end else if (cond_q[C_EO_TIMEOUT]) begin
                    o_network_status_indicator <= {fast_q, 2'b00};
                end else if (!cond_q[C_APP_CONN]) begin
                    o_network_status_indicator <= {slow_q, 2'b00};
                end else begin
                    o_network_status_indicator <= 3'b000;
                end
            end else if (cond_q[C_IP_CONFLICT]) begin
                o_network_status_indicator <= 3'b001;
            end else if (cond_q[C_EO_TIMEOUT]) begin
                o_network_status_indicator <= {2'b00, mid_q};
            end else if (cond_q[C_APP_CONN]) begin
                o_network_status_indicator <= 3'b010;
            end else begin
                o_network_status_indicator <= {1'b0, mid_q, 1'b0};
            end
            // Port LEDs: colour by rate, flash on activity
            o_port_one_link_activity_indicator <= '{
                green:  i_port_link[0] & i_port_fast[0] & (~i_port_act[0] | mid_q),
                yellow: i_port_link[0] & ~i_port_fast[0] & (~i_port_act[0] | mid_q)};
            o_port_two_link_activity_indicator <= '{
                green:  i_port_link[1] & i_port_fast[1] & (~i_port_act[1] | mid_q),
                yellow: i_port_link[1] & ~i_port_fast[1] & (~i_port_act[1] | mid_q)};
        end
    end

    // AXI write: address and data accepted in either order
    assign o_awready = ~aw_held_q & ~o_bvalid;
    assign o_wready  = ~w_held_q & ~o_bvalid;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            o_bvalid  <= 1'b0;
            o_bresp   <= AXI_OKAY;
            cond_q    <= '0;
            ctrl_q    <= CTRL_RESET;
        end else if (i_ce) begin
            if (i_awvalid && o_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
            end
            // Self-test request is a one-shot
            if (ctrl_q[K_SELFTEST]) begin
                ctrl_q[K_SELFTEST] <= 1'b0;
            end
            if (aw_held_q && w_held_q) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                o_bvalid  <= 1'b1;
                o_bresp   <= AXI_OKAY;
                unique case (awaddr_q)
                    OFS_COND: begin
                        for (int b = 0; b < 4; b++) begin
                            if (wstrb_q[b]) begin
                                for (int k = 0; k < 8; k++) begin
                                    if (b * 8 + k < COND_W) begin
                                        cond_q[b * 8 + k] <= wdata_q[b * 8 + k];
                                    end
                                end
                            end
                        end
                    end
                    OFS_CTRL: begin
                        if (wstrb_q[0]) begin
                            ctrl_q <= wdata_q[1:0];
                        end
                    end
                    OFS_STATUS, OFS_LED: begin
                        // Read-only, write ignored
                    end
                    default: begin
                        o_bresp <= AXI_DECERR;
                    end
                endcase
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Live LED state word for software
    assign led_word = {19'h0_0000, o_port_two_link_activity_indicator, o_port_one_link_activity_indicator,
                       o_network_status_indicator, o_module_status_indicator, o_maintenance_indicator,
                       o_bus_fault_indicator, o_system_fault_indicator, o_supply_indicator};

    // AXI read: one cycle to answer
    assign o_arready = ~o_rvalid;
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_rvalid <= 1'b0;
            o_rdata  <= '0;
            o_rresp  <= AXI_OKAY;
        end else if (i_ce) begin
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rresp  <= AXI_OKAY;
                unique case (i_araddr)
                    OFS_COND:   o_rdata <= 32'(cond_q);
                    OFS_CTRL:   o_rdata <= {30'h0000_0000, ctrl_q};
                    OFS_STATUS: o_rdata <= {28'h000_0000, fast_q, slow_q, mid_q, testing};
                    OFS_LED:    o_rdata <= led_word;
                    default: begin
                        o_rdata <= RESP_OKAY;
                        o_rresp <= AXI_DECERR;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end

    // Checks
    a_supply_follow: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce |=> o_supply_indicator == $past(i_supply_ok)) else $error("supply LED wrong");
    a_sf_steady: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && cond_q[C_NEW_DIAG] |=> o_system_fault_indicator) else $error("system fault not red");
    a_bf_steady: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && cond_q[C_NO_FBUS] |=> o_bus_fault_indicator) else $error("bus fault not red");
    a_mt_follow: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce |=> o_maintenance_indicator == $past(cond_q[C_SBUS_ERR] | cond_q[C_FBUS_ERR]))
        else $error("maintenance LED wrong");
    a_ms_multi: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && !testing && mism > 7'h01 |=> o_module_status_indicator == '{red: 1'b1, green: 1'b0})
        else $error("module status not red");
    a_ns_conflict: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && !testing && !ctrl_q[K_YELLOW] && cond_q[C_IP_CONFLICT] |=> o_network_status_indicator == 3'b001)
        else $error("network status not red");
    a_ns_off: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && !testing && ctrl_q[K_YELLOW] && cond_q[C_IP_VALID] && !cond_q[C_IP_CONFLICT]
        && !cond_q[C_EO_TIMEOUT] && cond_q[C_APP_CONN] |=> o_network_status_indicator == 3'b000)
        else $error("network status not off");
    a_port_colour: assert property (@(posedge i_clk) disable iff (i_srst)
        !(o_port_one_link_activity_indicator.green && o_port_one_link_activity_indicator.yellow))
        else $error("port LED both colours");
    a_port_steady: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && i_port_link[0] && !i_port_act[0] |=> o_port_one_link_activity_indicator.green == $past(i_port_fast[0])
        && o_port_one_link_activity_indicator.yellow != $past(i_port_fast[0])) else $error("port colour wrong");
    a_test_pair: assert property (@(posedge i_clk) disable iff (i_srst)
        i_ce && testing |=> o_module_status_indicator.red != o_module_status_indicator.green)
        else $error("self-test colour clash");
    c_selftest_done: cover property (@(posedge i_clk) disable iff (i_srst) $fell(testing));
    c_force_flash: cover property (@(posedge i_clk) disable iff (i_srst)
        cond_q[C_FORCE] && $rose(o_system_fault_indicator));
    c_port_act: cover property (@(posedge i_clk) disable iff (i_srst)
        i_port_act[0] && $fell(o_port_one_link_activity_indicator.green));
    c_write_done: cover property (@(posedge i_clk) disable iff (i_srst) o_bvalid && i_bready);
endmodule
`default_nettype wire

// ### include/led_status_pkg.sv
/*
 * Shared constants and types for the adapter status indicator controller:
 * register offsets, field positions, flash timing and the LED drive struct.
 * Assumes a 100 MHz system clock and 32-bit AXI4-Lite register access.
 */
`default_nettype none
package led_status_pkg;
    // Clock rate and flash timing
    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned SLOW_HZ       = 1;
    localparam int unsigned MID_HZ        = 2;
    localparam int unsigned FAST_HZ       = 4;
    // Half periods in cycles, rounded down
    localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
    localparam int unsigned MID_HALF_CYC  = CLK_HZ / (2 * MID_HZ);
    localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
    localparam int unsigned SELFTEST_STEPS = 4;

    // Register byte offsets
    localparam logic [7:0] OFS_COND   = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_LED    = 8'h0C;

    // Condition register field positions
    localparam int unsigned C_CFG_ERR     = 0;
    localparam int unsigned C_ADP_ERR     = 1;
    localparam int unsigned C_MOD_ERR     = 2;
    localparam int unsigned C_NEW_DIAG    = 3;
    localparam int unsigned C_FORCE       = 4;
    localparam int unsigned C_NO_FBUS     = 5;
    localparam int unsigned C_NO_CTRL     = 6;
    localparam int unsigned C_PARAM_ERR   = 7;
    localparam int unsigned C_SBUS_ERR    = 8;
    localparam int unsigned C_FBUS_ERR    = 9;
    localparam int unsigned C_MOD_DIAG    = 10;
    localparam int unsigned C_READY       = 11;
    localparam int unsigned C_UNCONF      = 12;
    localparam int unsigned C_IP_CONFLICT = 13;
    localparam int unsigned C_EO_TIMEOUT  = 14;
    localparam int unsigned C_APP_CONN    = 15;
    localparam int unsigned C_IP_VALID    = 16;
    localparam int unsigned C_MISMATCH_LSB = 20;
    localparam int unsigned MISMATCH_W    = 7;
    localparam int unsigned COND_W        = 27;

    // Control register fields
    localparam int unsigned K_YELLOW      = 0;
    localparam int unsigned K_SELFTEST    = 1;
    localparam logic [1:0]  CTRL_RESET    = 2'h0;

    localparam logic [31:0] RESP_OKAY     = 32'h0000_0000;
    localparam logic [1:0]  AXI_OKAY      = 2'b00;
    localparam logic [1:0]  AXI_DECERR    = 2'b11;

    // One two-colour LED drive
    typedef struct packed {
        logic red;
        logic green;
    } rg_led_t;

    // Per-port link indication
    typedef struct packed {
        logic green;
        logic yellow;
    } port_led_t;

    // Self-test sequencer states
    typedef enum logic [2:0] {
        ST_RED   = 3'b001,
        ST_GREEN = 3'b010,
        ST_RUN   = 3'b100
    } test_state_t;
endpackage
`default_nettype wire

// ### dv/led_panel_model.sv
/* Operator's eye on the front panel: counts level changes of each lamp.
   Assumes the lamps are packed into one vector by the bench. */
`default_nettype none
module led_panel_model (
    // Clock and window clear
    input  wire logic        i_clk,
    input  wire logic        i_clr,
    // Lamp levels as seen on the panel
    input  wire logic [12:0] i_leds,
    // Changes seen per lamp since the last clear
    output logic [7:0]       o_toggles [13]
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [12:0] last_q; // Levels one cycle ago
    // Saturating counts, so a runaway flasher cannot wrap to a steady look
    always_ff @(posedge i_clk) begin
        last_q <= i_leds;
        for (int k = 0; k < 13; k++) begin
            if (i_clr) begin
                o_toggles[k] <= 8'h00;
            end else if (last_q[k] != i_leds[k] && o_toggles[k] != 8'hff) begin
                o_toggles[k] <= o_toggles[k] + 8'h01;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/adapter_status_led_controller_tb_top.sv
/* Bench for the indicator controller: AXI4-Lite master, condition table.
   Assumes the panel model counts lamp changes over a clear window. */
`default_nettype none
module adapter_status_led_controller_tb_top import led_status_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] cond;
        logic        yel;
        logic [5:0]  port;
        logic [3:0]  bitn;
        logic [4:0]  lo;
        logic [4:0]  hi;
        logic        lvl;
    } case_t;
    // Condition word, scheme, {link,act,fast}, lamp, change range, level
    localparam case_t TBL [28] = '{
        '{0, 0, 0, 12, 0, 0, 1},
        '{1 << C_CFG_ERR, 0, 0, 11, 0, 0, 1},
        '{1 << C_FORCE, 0, 0, 11, 7, 9, 0},
        '{(1 << C_CFG_ERR) | (1 << C_FORCE), 0, 0, 11, 0, 0, 1},
        '{1 << C_NO_FBUS, 0, 0, 10, 0, 0, 1},
        '{1 << C_NO_CTRL, 0, 0, 10, 7, 9, 0},
        '{1 << C_SBUS_ERR, 0, 0, 9, 0, 0, 1},
        '{1 << C_FBUS_ERR, 0, 0, 9, 0, 0, 1},
        '{2 << C_MISMATCH_LSB, 0, 0, 8, 0, 0, 1},
        '{1 << C_MISMATCH_LSB, 0, 0, 8, 7, 9, 0},
        '{1 << C_MOD_DIAG, 0, 0, 8, 7, 9, 0},
        '{1 << C_READY, 0, 0, 7, 0, 0, 1},
        '{1 << C_UNCONF, 0, 0, 7, 7, 9, 0},
        '{(2 << C_MISMATCH_LSB) | (1 << C_READY), 0, 0, 7, 0, 0, 0},
        '{1 << C_IP_CONFLICT, 0, 0, 4, 0, 0, 1},
        '{1 << C_EO_TIMEOUT, 0, 0, 4, 7, 9, 0},
        '{1 << C_APP_CONN, 0, 0, 5, 0, 0, 1},
        '{0, 0, 0, 5, 7, 9, 0},
        '{(1 << C_APP_CONN) | (1 << C_IP_VALID), 1, 0, 6, 0, 0, 0},
        '{1 << C_IP_CONFLICT, 1, 0, 6, 0, 0, 1},
        '{0, 1, 0, 6, 0, 0, 1},
        '{1 << C_IP_VALID, 1, 0, 6, 3, 5, 0},
        '{(1 << C_EO_TIMEOUT) | (1 << C_IP_VALID), 1, 0, 6, 15, 17, 0},
        '{0, 0, 6'h11, 3, 0, 0, 1},
        '{0, 0, 6'h15, 3, 7, 9, 0},
        '{0, 0, 6'h20, 0, 0, 0, 1},
        '{0, 0, 6'h14, 2, 7, 9, 0},
        '{0, 0, 6'h2a, 1, 7, 9, 0}
    };
    logic        clk, srst, clr, supply_ok, awv, wv, bre, arv, rre;
    logic [7:0]  awa, ara;
    logic [31:0] wd, r_dat;
    logic [1:0]  lnk, act, fst, b_rsp, r_rsp;
    logic        aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, sup, sf, bf, mt;
    rg_led_t     ms;
    logic [2:0]  ns;
    port_led_t   p1, p2;
    logic [7:0]  tog [13];
    logic [12:0] leds;
    logic [31:0] seed = 32'h07f3_1a1c;
    int          mismatches, checked, cyc;
    logic [1:0]  wq [$]; // Expected write responses
    logic [33:0] rq [$]; // Expected {rresp, rdata}
    assign leds = {sup, sf, bf, mt, ms, ns, p1, p2};
    led_status_ctrl #(.SLOW_HALF(8), .MID_HALF(4), .FAST_HALF(2)) u_led_status_ctrl (
        .i_clk(clk), .i_srst(srst), .i_ce(1'b1), .i_supply_ok(supply_ok), .i_port_link(lnk),
        .i_port_act(act), .i_port_fast(fst), .i_awaddr(awa), .i_awvalid(awv), .o_awready(aw_rdy),
        .i_wdata(wd), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(w_rdy), .o_bresp(b_rsp), .o_bvalid(b_vld),
        .i_bready(bre), .i_araddr(ara), .i_arvalid(arv), .o_arready(ar_rdy), .o_rdata(r_dat),
        .o_rresp(r_rsp), .o_rvalid(r_vld), .i_rready(rre), .o_supply_indicator(sup),
        .o_system_fault_indicator(sf), .o_bus_fault_indicator(bf), .o_maintenance_indicator(mt),
        .o_module_status_indicator(ms), .o_network_status_indicator(ns),
        .o_port_one_link_activity_indicator(p1), .o_port_two_link_activity_indicator(p2));
    led_panel_model u_led_panel_model (.i_clk(clk), .i_clr(clr), .i_leds(leds), .o_toggles(tog));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task chk(input logic [33:0] s, input logic [33:0] e);
        checked++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task results;
        $display("mismatches=%0d checked=%0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Address and data go out together; each drops once its own ready is seen
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        logic ad, dd;
        @(posedge clk);
        wq.push_back(r);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        ad = 1'b0;
        dd = 1'b0;
        while (!(ad && dd)) begin
            @(posedge clk);
            if (!ad && aw_rdy) begin
                awv <= 1'b0;
                ad = 1'b1;
            end
            if (!dd && w_rdy) begin
                wv <= 1'b0;
                dd = 1'b1;
            end
        end
        do @(posedge clk); while (!b_vld);
        bre <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        rq.push_back({r, d});
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do @(posedge clk); while (!ar_rdy);
        arv <= 1'b0;
        do @(posedge clk); while (!r_vld);
        rre <= 1'b0;
    endtask
    // Answers are judged when their handshake completes
    always @(posedge clk) begin
        cyc++;
        if (b_vld && bre) chk(b_rsp, wq.pop_front());
        if (r_vld && rre) chk({r_rsp, r_dat}, rq.pop_front());
        if (cyc == 6000) begin
            mismatches++;
            results();
        end
    end
    initial begin
        {awv, wv, bre, arv, rre, awa, ara, wd, lnk, act, fst} = '0;
        srst = 1'b1;
        clr = 1'b1;
        supply_ok = 1'b1;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        clr <= 1'b0;
        repeat (20) @(posedge clk);
        chk(tog[8] inside {[3:5]}, 1'b1);
        chk(tog[4] inside {[3:5]}, 1'b1);
        for (int i = 0; i < 28; i++) begin
            {lnk, act, fst} <= TBL[i].port;
            wr(OFS_COND, TBL[i].cond, AXI_OKAY);
            wr(OFS_CTRL, {31'h0000_0000, TBL[i].yel}, AXI_OKAY);
            rd(OFS_COND, TBL[i].cond, AXI_OKAY);
            repeat (4) @(posedge clk);
            clr <= 1'b1;
            @(posedge clk);
            clr <= 1'b0;
            repeat (32) @(posedge clk);
            chk(tog[TBL[i].bitn] inside {[TBL[i].lo:TBL[i].hi]}, 1'b1);
            if (TBL[i].hi == 0) chk(leds[TBL[i].bitn], TBL[i].lvl);
        end
        // Read-only and unmapped places leave the condition word alone
        wr(OFS_STATUS, $random(seed), AXI_OKAY);
        wr(8'h10, $random(seed), AXI_DECERR);
        rd(8'h10, 32'h0000_0000, AXI_DECERR);
        rd(OFS_COND, 32'h0000_0000, AXI_OKAY);
        // Software rerun of the lamp test: red and green alternate again
        wr(OFS_CTRL, 32'h0000_0002, AXI_OKAY);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (20) @(posedge clk);
        chk(tog[8] inside {[3:5]}, 1'b1);
        chk(tog[4] inside {[3:5]}, 1'b1);
        supply_ok <= 1'b0;
        repeat (4) @(posedge clk);
        chk(sup, 1'b0);
        results();
    end
endmodule
`default_nettype wire
